// >>> core/cep_pkg.sv
// package: constants, types and register map of the exception prioritizer
package cep_pkg;

    // avalon register byte offsets
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h0;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_DEBUG_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;

    // debug control register fields
    localparam int DBG_BRK_BIT = 0;
    localparam int DBG_STEP_BIT = 1;

    // cause codes, in priority order
    typedef enum logic [4:0] {
        CEP_EXC_NONE,
        CEP_EXC_RESET,
        CEP_EXC_DSS,
        CEP_EXC_DEBUG_INTERRUPT_EXC,
        CEP_EXC_NMI,
        CEP_EXC_INT,
        CEP_EXC_DIB,
        CEP_EXC_FETCH_ADDR,
        CEP_EXC_IBUS,
        CEP_EXC_SWBP,
        CEP_EXC_SYSTEM_CALL_INSTR,
        CEP_EXC_BREAK,
        CEP_EXC_RESV,
        CEP_EXC_CPU,
        CEP_EXC_EXTU,
        CEP_EXC_OVF,
        CEP_EXC_TRAP,
        CEP_EXC_DDB,
        CEP_EXC_LOAD_ADDR,
        CEP_EXC_STORE_ADDR,
        CEP_EXC_DBUS,
        CEP_EXC_LOAD_DATA_BREAK_EXC
    } cep_cause_t;

    localparam int NUM_CAUSE = 22;

    // raw pending-cause vector from pins, registers and the pipeline; index = cause code
    typedef logic [NUM_CAUSE-1:0] cep_vec_t;

    typedef enum logic [1:0] {
        CEP_RUN,
        CEP_DEBUG,
        CEP_SLEEP
    } cep_mode_t;

    // pipeline-side inputs carried together
    typedef struct packed {
        logic retire;
        logic single_step_done;
        logic ibrk_match;
        logic fetch_misaligned;
        logic fetch_protected;
        logic fetch_bus_err;
        logic sw_debug_bp_instr;
        logic system_call_instr;
        logic break_instr;
        logic reserved_opcode;
        logic cop_instr_disabled;
        logic ext_instr_disabled;
        logic trap_arith_ovf;
        logic trap_instr;
        logic trap_cond;
        logic dbrk_addr_only;
        logic dbrk_store_addr;
        logic dbrk_store_value;
        logic load_misaligned;
        logic load_protected;
        logic store_misaligned;
        logic store_protected;
        logic load_bus_err;
        logic store_bus_err;
        logic load_data_break;
        logic debug_return_instr;
        logic wait_instr;
    } cep_pipe_t;

    // answer to the pipeline
    typedef struct packed {
        logic take;
        logic flush;
        logic redirect;
        cep_cause_t cause;
        logic debug_mode;
        logic sleep;
    } cep_resp_t;

endpackage : cep_pkg

// >>> core/cep_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cep_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
        end
    end

    assign q = s2_ff;
endmodule : cep_sync
`default_nettype wire

// >>> core/cep_prio.sv
// fixed-priority picker over the cause vector
`timescale 1ns/1ps
`default_nettype none
module cep_prio (
    // raw pending causes
    input wire cep_pkg::cep_vec_t pend,
    // selected cause
    output var cep_pkg::cep_cause_t sel
);
    // lowest index wins
    always_comb begin
        sel = cep_pkg::CEP_EXC_NONE;
        for (int i = cep_pkg::NUM_CAUSE - 1; i >= 1; i--) begin
            if (pend[i]) begin
                sel = cep_pkg::cep_cause_t'(i[4:0]);
            end
        end
    end
endmodule : cep_prio
`default_nettype wire

// >>> core/cep_top.sv
// exception prioritizer top: cause collection, debug/sleep modes, registers
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module cep_top #(
    parameter int NUM_IRQ = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // pins from outside the core clock domain
    input wire logic master_clear_input,
    input wire logic ext_debug_interrupt_in,
    input wire logic nmi_in,
    input wire logic [NUM_IRQ-1:0] irq_src_in,
    // pipeline events
    input wire cep_pkg::cep_pipe_t pipe,
    // exception answer
    output var cep_pkg::cep_resp_t resp,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [NUM_IRQ-1:0] flag;
        logic [NUM_IRQ-1:0] enable;
        logic dbg_brk;
        logic dbg_step;
        cep_pkg::cep_mode_t mode;
        cep_pkg::cep_cause_t last_cause;
        cep_pkg::cep_resp_t resp;
        logic [31:0] rdata;
        logic ack;
        logic [NUM_IRQ-1:0] irq_prev;
        logic por_done;
    } cep_state_t;

    cep_state_t st_ff;
    cep_state_t nxt_st;

    // ==========================================================
    // pin synchronisers
    logic master_clear_input_s;
    logic debug_interrupt_exc_s;
    logic nmi_s;
    logic [NUM_IRQ-1:0] irq_s;

    cep_sync #(.W(3 + NUM_IRQ)) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .d({master_clear_input, ext_debug_interrupt_in, nmi_in, irq_src_in}),
        .q({master_clear_input_s, debug_interrupt_exc_s, nmi_s, irq_s})
    );

    // ==========================================================
    // cause collection
    cep_pkg::cep_vec_t pend;
    cep_pkg::cep_cause_t sel;
    logic irq_any;
    logic in_debug;

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    assign in_debug = (st_ff.mode == cep_pkg::CEP_DEBUG);
    assign irq_any = |(st_ff.flag & st_ff.enable);

    always_comb begin
        pend = '0;
        pend[cep_pkg::CEP_EXC_RESET] = master_clear_input_s | ~st_ff.por_done;
        pend[cep_pkg::CEP_EXC_DSS] = st_ff.dbg_step & pipe.single_step_done
                                     & ~in_debug;
        pend[cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC] = (debug_interrupt_exc_s | st_ff.dbg_brk) & ~in_debug;
        pend[cep_pkg::CEP_EXC_NMI] = nmi_s;
        pend[cep_pkg::CEP_EXC_INT] = irq_any & ~in_debug;
        pend[cep_pkg::CEP_EXC_DIB] = pipe.ibrk_match & ~in_debug;
        pend[cep_pkg::CEP_EXC_FETCH_ADDR] = pipe.fetch_misaligned
                                            | pipe.fetch_protected;
        pend[cep_pkg::CEP_EXC_IBUS] = pipe.fetch_bus_err;
        pend[cep_pkg::CEP_EXC_SWBP] = pipe.sw_debug_bp_instr;
        pend[cep_pkg::CEP_EXC_SYSTEM_CALL_INSTR] = pipe.system_call_instr;
        pend[cep_pkg::CEP_EXC_BREAK] = pipe.break_instr;
        pend[cep_pkg::CEP_EXC_RESV] = pipe.reserved_opcode;
        pend[cep_pkg::CEP_EXC_CPU] = pipe.cop_instr_disabled;
        pend[cep_pkg::CEP_EXC_EXTU] = pipe.ext_instr_disabled;
        pend[cep_pkg::CEP_EXC_OVF] = pipe.trap_arith_ovf;
        pend[cep_pkg::CEP_EXC_TRAP] = pipe.trap_instr & pipe.trap_cond;
        pend[cep_pkg::CEP_EXC_DDB] = (pipe.dbrk_addr_only
                                      | (pipe.dbrk_store_addr & pipe.dbrk_store_value))
                                     & ~in_debug;
        pend[cep_pkg::CEP_EXC_LOAD_ADDR] = pipe.load_misaligned
                                           | pipe.load_protected;
        pend[cep_pkg::CEP_EXC_STORE_ADDR] = pipe.store_misaligned
                                            | pipe.store_protected;
        pend[cep_pkg::CEP_EXC_DBUS] = pipe.load_bus_err | pipe.store_bus_err;
        pend[cep_pkg::CEP_EXC_LOAD_DATA_BREAK_EXC] = pipe.load_data_break & ~in_debug;
    end

    cep_prio u_prio (
        .pend(pend),
        .sel(sel)
    );

    function automatic logic is_debug_cause(input cep_pkg::cep_cause_t c);
        return (c == cep_pkg::CEP_EXC_DSS) || (c == cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC)
            || (c == cep_pkg::CEP_EXC_DIB) || (c == cep_pkg::CEP_EXC_SWBP)
            || (c == cep_pkg::CEP_EXC_DDB) || (c == cep_pkg::CEP_EXC_LOAD_DATA_BREAK_EXC);
    endfunction : is_debug_cause

    // ==========================================================
    // next state
    logic bus_req;
    logic bus_wr;
    logic wake;

    assign bus_req = (avs_read | avs_write) & ~st_ff.ack;
    assign bus_wr = avs_write & st_ff.ack;
    assign wake = irq_any | nmi_s | debug_interrupt_exc_s | st_ff.dbg_brk | master_clear_input_s;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.por_done = 1'b1;
        nxt_st.irq_prev = irq_s;
        nxt_st.resp.take = 1'b0;
        nxt_st.resp.flush = 1'b0;
        nxt_st.resp.redirect = st_ff.resp.flush;
        nxt_st.ack = 1'b0;
        // interrupt flags: hardware set wins over software clear
        if (bus_wr && avs_address == cep_pkg::ADDR_IRQ_FLAG) begin
            nxt_st.flag = merge_be(st_ff.flag, avs_writedata, avs_byteenable);
        end
        if (bus_wr && avs_address == cep_pkg::ADDR_IRQ_ENABLE) begin
            nxt_st.enable = merge_be(st_ff.enable, avs_writedata, avs_byteenable);
        end
        if (bus_wr && avs_address == cep_pkg::ADDR_DEBUG_CTRL
            && avs_byteenable[0]) begin
            nxt_st.dbg_brk = avs_writedata[cep_pkg::DBG_BRK_BIT];
            nxt_st.dbg_step = avs_writedata[cep_pkg::DBG_STEP_BIT];
        end
        nxt_st.flag = nxt_st.flag | (irq_s & ~st_ff.irq_prev);
        // bus answer one cycle after the request
        if (bus_req) begin
            nxt_st.ack = 1'b1;
            case (avs_address)
                cep_pkg::ADDR_IRQ_FLAG: nxt_st.rdata = st_ff.flag;
                cep_pkg::ADDR_IRQ_ENABLE: nxt_st.rdata = st_ff.enable;
                cep_pkg::ADDR_DEBUG_CTRL: nxt_st.rdata = {30'h0000_0000,
                                                           st_ff.dbg_step, st_ff.dbg_brk};
                cep_pkg::ADDR_STATUS: nxt_st.rdata = {25'h000_0000, st_ff.mode,
                                                       st_ff.last_cause};
                default: nxt_st.rdata = cep_pkg::UNMAPPED_WORD;
            endcase
        end
        // mode machine
        case (st_ff.mode)
            cep_pkg::CEP_RUN: begin
                if (pipe.wait_instr && sel == cep_pkg::CEP_EXC_NONE) begin
                    nxt_st.mode = cep_pkg::CEP_SLEEP;
                end
            end
            cep_pkg::CEP_DEBUG: begin
                if (pipe.debug_return_instr) begin
                    nxt_st.mode = cep_pkg::CEP_RUN;
                end
            end
            cep_pkg::CEP_SLEEP: begin
                if (wake) begin
                    nxt_st.mode = cep_pkg::CEP_RUN;
                end
            end
            default: nxt_st.mode = cep_pkg::CEP_RUN;
        endcase
        // take the selected exception
        if (sel != cep_pkg::CEP_EXC_NONE) begin
            nxt_st.resp.take = 1'b1;
            nxt_st.resp.flush = 1'b1;
            nxt_st.resp.cause = sel;
            nxt_st.last_cause = sel;
            if (sel == cep_pkg::CEP_EXC_RESET) begin
                nxt_st.mode = cep_pkg::CEP_RUN;
            end else if (is_debug_cause(sel)) begin
                nxt_st.mode = cep_pkg::CEP_DEBUG;
                if (sel == cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC) begin
                    nxt_st.dbg_brk = nxt_st.dbg_brk & ~st_ff.dbg_brk;
                end
            end else if (st_ff.mode == cep_pkg::CEP_SLEEP) begin
                nxt_st.mode = cep_pkg::CEP_RUN;
            end
        end
        nxt_st.resp.debug_mode = (nxt_st.mode == cep_pkg::CEP_DEBUG);
        nxt_st.resp.sleep = (nxt_st.mode == cep_pkg::CEP_SLEEP);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign resp = st_ff.resp;
    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = ~st_ff.ack;

    // ==========================================================
    // checks
    property p_master_clear_input_take;
        @(posedge ref_clk) disable iff (srst)
        $rose(master_clear_input_s) |=> resp.take && resp.cause == cep_pkg::CEP_EXC_RESET;
    endproperty
    a_master_clear_input_take: assert property (p_master_clear_input_take) else $error("reset cause not taken");

    property p_nmi_over_int;
        @(posedge ref_clk) disable iff (srst)
        (nmi_s && !pend[cep_pkg::CEP_EXC_RESET] && !pend[cep_pkg::CEP_EXC_DSS]
            && !pend[cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC]) |=> resp.cause == cep_pkg::CEP_EXC_NMI;
    endproperty
    a_nmi_over_int: assert property (p_nmi_over_int) else $error("nmi lost priority");

    property p_int_masked;
        @(posedge ref_clk) disable iff (srst)
        (st_ff.flag & st_ff.enable) == '0 |=> resp.cause != cep_pkg::CEP_EXC_INT || !resp.take;
    endproperty
    a_int_masked: assert property (p_int_masked) else $error("masked interrupt taken");

    property p_trap_cond;
        @(posedge ref_clk) disable iff (srst)
        (pipe.trap_instr && !pipe.trap_cond) |=> resp.cause != cep_pkg::CEP_EXC_TRAP
            || !resp.take;
    endproperty
    a_trap_cond: assert property (p_trap_cond) else $error("trap without condition");

    property p_flush_redirect;
        @(posedge ref_clk) disable iff (srst)
        resp.flush |=> resp.redirect;
    endproperty
    a_flush_redirect: assert property (p_flush_redirect) else $error("no redirect after flush");

    property p_debug_hold;
        @(posedge ref_clk) disable iff (srst)
        (in_debug && !pipe.debug_return_instr && sel != cep_pkg::CEP_EXC_RESET)
            |=> resp.debug_mode;
    endproperty
    a_debug_hold: assert property (p_debug_hold) else $error("debug mode left early");

    property p_wait_sleep;
        @(posedge ref_clk) disable iff (srst)
        (st_ff.mode == cep_pkg::CEP_RUN && pipe.wait_instr && sel == cep_pkg::CEP_EXC_NONE)
            |=> resp.sleep;
    endproperty
    a_wait_sleep: assert property (p_wait_sleep) else $error("wait did not sleep");

    property p_bus_answer;
        @(posedge ref_clk) disable iff (srst)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_swbp_debug;
        @(posedge ref_clk) disable iff (srst)
        (sel == cep_pkg::CEP_EXC_SWBP) |=> resp.debug_mode ##1 resp.redirect;
    endproperty
    a_swbp_debug: assert property (p_swbp_debug) else $error("breakpoint no debug");

    property p_por_take;
        @(posedge ref_clk) disable iff (srst)
        !st_ff.por_done |=> resp.take && resp.cause == cep_pkg::CEP_EXC_RESET;
    endproperty
    a_por_take: assert property (p_por_take) else $error("power-on reset not taken");

    property p_dss_take;
        @(posedge ref_clk) disable iff (srst)
        (st_ff.dbg_step && pipe.single_step_done && !in_debug && !pend[cep_pkg::CEP_EXC_RESET])
            |=> resp.take && resp.cause == cep_pkg::CEP_EXC_DSS;
    endproperty
    a_dss_take: assert property (p_dss_take) else $error("single step missed");

    property p_debug_interrupt_exc_take;
        @(posedge ref_clk) disable iff (srst)
        (debug_interrupt_exc_s && !in_debug && !pend[cep_pkg::CEP_EXC_RESET] && !pend[cep_pkg::CEP_EXC_DSS])
            |=> resp.take && resp.cause == cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC;
    endproperty
    a_debug_interrupt_exc_take: assert property (p_debug_interrupt_exc_take) else $error("debug interrupt missed");

    property p_int_take;
        @(posedge ref_clk) disable iff (srst)
        (irq_any && !in_debug && !nmi_s && !pend[cep_pkg::CEP_EXC_RESET]
            && !pend[cep_pkg::CEP_EXC_DSS] && !pend[cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC])
            |=> resp.take && resp.cause == cep_pkg::CEP_EXC_INT;
    endproperty
    a_int_take: assert property (p_int_take) else $error("interrupt missed");

    property p_dbg_return;
        @(posedge ref_clk) disable iff (srst)
        (in_debug && pipe.debug_return_instr && sel == cep_pkg::CEP_EXC_NONE)
            |=> !resp.debug_mode;
    endproperty
    a_dbg_return: assert property (p_dbg_return) else $error("debug not left");

    property p_sleep_wake;
        @(posedge ref_clk) disable iff (srst)
        (st_ff.mode == cep_pkg::CEP_SLEEP && nmi_s) |=> !resp.sleep;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("no wake from sleep");

    property p_flag_set;
        @(posedge ref_clk) disable iff (srst)
        (irq_s & ~st_ff.irq_prev) != '0
            |=> (st_ff.flag & $past(irq_s) & ~$past(st_ff.irq_prev))
                == ($past(irq_s) & ~$past(st_ff.irq_prev));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("irq flag not set");

endmodule : cep_top
`default_nettype wire

// >>> bench/cep_pipe_model.sv
// pipeline partner model: issues one-cycle pipeline events
`timescale 1ns/1ps
`default_nettype none
module cep_pipe_model (
    // clock
    input wire logic ref_clk,
    // events toward the prioritizer
    output var cep_pkg::cep_pipe_t pipe
);
    initial pipe = '0;

    // ==========
    // issue an event after gap idle cycles, held for one cycle
    task automatic issue(input cep_pkg::cep_pipe_t p, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        pipe <= p;
        @(posedge ref_clk);
        pipe <= '0;
    endtask : issue
endmodule : cep_pipe_model
`default_nettype wire

// >>> bench/cep_top_bench.sv
// self-checking bench of the exception prioritizer
`timescale 1ns/1ps
`default_nettype none
module cep_top_bench;
    // ==========
    // clock, pins, bus and model state
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] pin_v = 3'h0;
    logic [31:0] irq = 32'h0000_0000;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wreq;
    cep_pkg::cep_pipe_t pipe;
    cep_pkg::cep_resp_t resp;
    int n_fail = 0;
    int n_compared = 0;
    int n_lvl = 0;
    int k;
    cep_pkg::cep_cause_t exp_q[$];
    logic lvl_on = 1'b0;
    logic prev_take = 1'b0;
    logic [31:0] r;
    logic [31:0] v;
    cep_pkg::cep_pipe_t p;
    cep_pkg::cep_cause_t c;

    always #2 ref_clk = ~ref_clk;

    cep_pipe_model u_cep_pipe_model (.ref_clk(ref_clk), .pipe(pipe));
    cep_top u_cep_top (.ref_clk(ref_clk), .srst(srst), .master_clear_input(pin_v[2]),
        .ext_debug_interrupt_in(pin_v[1]), .nmi_in(pin_v[0]), .irq_src_in(irq), .pipe(pipe),
        .resp(resp), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq));

    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        chk("bus_answer", 0, n >= 20);
    endtask : bus

    task automatic settle;
        repeat (8) @(posedge ref_clk);
    endtask : settle

    task automatic pulse(input int i);
        @(posedge ref_clk);
        pin_v[i] <= 1'b1;
        @(posedge ref_clk);
        pin_v[i] <= 1'b0;
    endtask : pulse

    task automatic dbg_exit;
        settle;
        chk("debug_mode", 1, resp.debug_mode);
        p = '0;
        p.debug_return_instr = 1'b1;
        u_cep_pipe_model.issue(p, 0);
        settle;
        chk("debug_mode", 0, resp.debug_mode);
    endtask : dbg_exit

    task automatic summarize;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // ==========
    // one pipeline event per entry and the cause it must raise, none for entries 12 and 15
    function automatic void mk(input int i, output cep_pkg::cep_pipe_t q,
                               output cep_pkg::cep_cause_t e);
        q = '0;
        q.retire = 1'b1;
        e = cep_pkg::CEP_EXC_NONE;
        case (i)
            0: begin q.ibrk_match = 1'b1; e = cep_pkg::CEP_EXC_DIB; end
            1: begin q.fetch_misaligned = 1'b1; e = cep_pkg::CEP_EXC_FETCH_ADDR; end
            2: begin q.fetch_protected = 1'b1; e = cep_pkg::CEP_EXC_FETCH_ADDR; end
            3: begin q.fetch_bus_err = 1'b1; e = cep_pkg::CEP_EXC_IBUS; end
            4: begin q.sw_debug_bp_instr = 1'b1; e = cep_pkg::CEP_EXC_SWBP; end
            5: begin q.system_call_instr = 1'b1; e = cep_pkg::CEP_EXC_SYSTEM_CALL_INSTR; end
            6: begin q.break_instr = 1'b1; e = cep_pkg::CEP_EXC_BREAK; end
            7: begin q.reserved_opcode = 1'b1; e = cep_pkg::CEP_EXC_RESV; end
            8: begin q.cop_instr_disabled = 1'b1; e = cep_pkg::CEP_EXC_CPU; end
            9: begin q.ext_instr_disabled = 1'b1; e = cep_pkg::CEP_EXC_EXTU; end
            10: begin q.trap_arith_ovf = 1'b1; e = cep_pkg::CEP_EXC_OVF; end
            11: begin q.trap_instr = 1'b1; q.trap_cond = 1'b1; e = cep_pkg::CEP_EXC_TRAP; end
            12: q.trap_instr = 1'b1;
            13: begin q.dbrk_addr_only = 1'b1; e = cep_pkg::CEP_EXC_DDB; end
            14: begin q.dbrk_store_addr = 1'b1; q.dbrk_store_value = 1'b1; e = cep_pkg::CEP_EXC_DDB; end
            15: q.dbrk_store_addr = 1'b1;
            16: begin q.load_misaligned = 1'b1; e = cep_pkg::CEP_EXC_LOAD_ADDR; end
            17: begin q.load_protected = 1'b1; e = cep_pkg::CEP_EXC_LOAD_ADDR; end
            18: begin q.store_misaligned = 1'b1; e = cep_pkg::CEP_EXC_STORE_ADDR; end
            19: begin q.store_protected = 1'b1; e = cep_pkg::CEP_EXC_STORE_ADDR; end
            20: begin q.load_bus_err = 1'b1; e = cep_pkg::CEP_EXC_DBUS; end
            21: begin q.store_bus_err = 1'b1; e = cep_pkg::CEP_EXC_DBUS; end
            default: begin q.load_data_break = 1'b1; e = cep_pkg::CEP_EXC_LOAD_DATA_BREAK_EXC; end
        endcase
    endfunction : mk

    // ==========
    // every taken exception is compared with the expected queue, except an interrupt taken while lvl_on is set, which is only counted
    always @(negedge ref_clk) begin
        if (!srst && (resp.take || prev_take)) begin
            chk("flush", resp.take, resp.flush);
            chk("redirect", prev_take, resp.redirect);
        end
        if (!srst && resp.take) begin
            if (lvl_on && resp.cause === cep_pkg::CEP_EXC_INT) begin
                n_lvl++;
            end else begin
                chk("cause", exp_q.size() > 0 ? exp_q[0] : cep_pkg::CEP_EXC_NONE, resp.cause);
                if (exp_q.size() > 0) exp_q.delete(0);
            end
        end
        prev_take <= resp.take & !srst;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        summarize;
    end

    // ==========
    // main sequence
    initial begin
        v = $urandom(74628);
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        exp_q.push_back(cep_pkg::CEP_EXC_RESET);
        settle;
        bus(0, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        chk("flag_reset", cep_pkg::RESET_WORD, r);
        bus(0, cep_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000, r);
        chk("enable_reset", cep_pkg::RESET_WORD, r);
        $display("test reset done");
        v = $urandom;
        bus(1, cep_pkg::ADDR_IRQ_ENABLE, v, r);
        bus(0, cep_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000, r);
        chk("enable", v, r);
        bus(1, cep_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000, r);
        v = $urandom;
        bus(1, cep_pkg::ADDR_IRQ_FLAG, v, r);
        bus(0, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        chk("flag", v, r);
        bus(1, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        be <= 4'h2;
        bus(1, cep_pkg::ADDR_IRQ_FLAG, 32'hFFFF_FFFF, r);
        be <= 4'hF;
        bus(0, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        chk("flag_lane", 32'h0000_FF00, r);
        bus(1, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        bus(1, 4'h2, $urandom, r);
        bus(0, 4'h2, 32'h0000_0000, r);
        chk("unmapped", cep_pkg::UNMAPPED_WORD, r);
        bus(1, cep_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r);
        bus(0, cep_pkg::ADDR_STATUS, 32'h0000_0000, r);
        chk("status", 32'(cep_pkg::CEP_EXC_RESET), r);
        $display("test registers done");
        k = $urandom_range(31, 0);
        @(posedge ref_clk);
        irq[k] <= 1'b1;
        @(posedge ref_clk);
        irq[k] <= 1'b0;
        settle;
        bus(0, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        chk("flag_set", 32'h0000_0001 << k, r);
        lvl_on = 1'b1;
        bus(1, cep_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001 << k, r);
        settle;
        chk("int_taken", 1, n_lvl > 0);
        p = '0;
        p.system_call_instr = 1'b1;
        u_cep_pipe_model.issue(p, 1);
        exp_q.push_back(cep_pkg::CEP_EXC_NMI);
        pulse(0);
        settle;
        bus(1, cep_pkg::ADDR_IRQ_FLAG, 32'h0000_0000, r);
        settle;
        lvl_on = 1'b0;
        chk("pending", 0, exp_q.size());
        $display("test interrupts done");
        for (int i = 0; i < 23; i++) begin
            mk(i, p, c);
            if (c != cep_pkg::CEP_EXC_NONE) exp_q.push_back(c);
            u_cep_pipe_model.issue(p, i % 3);
            settle;
            p = '0;
            p.debug_return_instr = 1'b1;
            u_cep_pipe_model.issue(p, 0);
            settle;
            chk("pending", 0, exp_q.size());
        end
        p = '0;
        p.fetch_bus_err = 1'b1;
        p.system_call_instr = 1'b1;
        p.store_misaligned = 1'b1;
        p.load_data_break = 1'b1;
        exp_q.push_back(cep_pkg::CEP_EXC_IBUS);
        u_cep_pipe_model.issue(p, 0);
        settle;
        chk("pending", 0, exp_q.size());
        $display("test causes done");
        exp_q.push_back(cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC);
        pulse(1);
        settle;
        p = '0;
        p.ibrk_match = 1'b1;
        u_cep_pipe_model.issue(p, 0);
        dbg_exit;
        exp_q.push_back(cep_pkg::CEP_EXC_DEBUG_INTERRUPT_EXC);
        bus(1, cep_pkg::ADDR_DEBUG_CTRL, 32'h0000_0001 << cep_pkg::DBG_BRK_BIT, r);
        dbg_exit;
        bus(1, cep_pkg::ADDR_DEBUG_CTRL, 32'h0000_0001 << cep_pkg::DBG_STEP_BIT, r);
        p = '0;
        p.single_step_done = 1'b1;
        exp_q.push_back(cep_pkg::CEP_EXC_DSS);
        u_cep_pipe_model.issue(p, 2);
        settle;
        bus(1, cep_pkg::ADDR_DEBUG_CTRL, 32'h0000_0000, r);
        dbg_exit;
        chk("pending", 0, exp_q.size());
        $display("test debug done");
        p = '0;
        p.wait_instr = 1'b1;
        u_cep_pipe_model.issue(p, 0);
        settle;
        chk("sleep", 1, resp.sleep);
        exp_q.push_back(cep_pkg::CEP_EXC_NMI);
        pulse(0);
        settle;
        chk("sleep", 0, resp.sleep);
        $display("test sleep done");
        exp_q.push_back(cep_pkg::CEP_EXC_RESET);
        pulse(2);
        settle;
        chk("pending", 0, exp_q.size());
        $display("test master clear done");
        summarize;
    end
endmodule : cep_top_bench
`default_nettype wire
